/* File: bmmd_pkg.sv */
// package: address map, field positions and reset values of the backplane decode
package bmmd_pkg;

    // ---------------------------------------------------------------
    // region codes, taken from address bits 15:12; the three-bit codes from bits 15:13
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_TOP_PROG_LAST = 4'h8;
    localparam logic [3:0] REG_SCSI_BUF      = 4'h9;
    localparam logic [3:0] REG_POWER         = 4'hA;
    localparam logic [3:0] REG_FAULT         = 4'hB;
    localparam logic [3:0] REG_PRESENCE      = 4'hC;
    localparam logic [3:0] REG_SCSI_IO       = 4'hD;
    localparam logic [2:0] REG_RAM_TOP3      = 3'h7;
    localparam logic [2:0] BOOT_TOP3         = 3'h0;

    // ---------------------------------------------------------------
    // register offsets (first alias of each region)
    // ---------------------------------------------------------------
    localparam logic [15:0] DRIVE_POWER_CONTROL_OFS   = 16'hA000;
    localparam logic [15:0] FAULT_LAMP_CONTROL_OFS    = 16'hB000;
    localparam logic [15:0] DRIVE_PRESENCE_STATUS_OFS = 16'hC000;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int          SLOT_COUNT           = 5;
    localparam int          PWR_CHASSIS_BIT      = 7;
    localparam int          PWR_SCSI_ID_BIT      = 5;
    localparam int          PRS_PRIMARY_BIT      = 6;
    localparam int          PRS_FORCE_UPD_BIT    = 5;
    localparam logic [7:0]  DRIVE_POWER_RESET    = 8'hDF;
    localparam logic [7:0]  FAULT_LAMP_RESET     = 8'h00;
    localparam int          SCSI_IO_ADDR_BITS    = 3;
    localparam int          RAM_ADDR_BITS        = 13;

    // region selector
    typedef enum {BMMD_PROG, BMMD_SCSI_BUF, BMMD_POWER, BMMD_FAULT,
                  BMMD_PRESENCE, BMMD_SCSI_IO, BMMD_RAM} bmmd_region_type;

endpackage : bmmd_pkg

/* File: bmmd_sync.sv */
// file: two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module bmmd_sync
    import bmmd_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // pins
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // first stage is read only by the second
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule : bmmd_sync

/* File: bmmd_ram.sv */
// file: 8 KB general program and data ram
`timescale 1ns/1ns
module bmmd_ram
    import bmmd_pkg::*;
(
    // clock
    input  wire logic                     mclk,
    // access
    input  wire logic                     wr_en,
    input  wire logic [RAM_ADDR_BITS-1:0] addr,
    input  wire logic [7:0]               wdata,
    output logic      [7:0]               rdata
);

    logic [7:0] mem [0:(1<<RAM_ADDR_BITS)-1];

    // synchronous write and registered read
    always_ff @(posedge mclk)
    begin
        if (wr_en)
            mem[addr] <= wdata;
        rdata <= mem[addr];
    end

endmodule : bmmd_ram

/* File: bmmd_decode.sv */
// file: memory map decode and control bytes of the drive backplane
//
// Behaviour
// - program region 0000h-8FFFh is writable as well as readable.
// - writes to the bottom 8 KB are blocked unless boot jumper allows.
// - scsi buffer window accesses assert dma ack plus read or write strobe.
// - any read in A000h-AFFFh returns the power byte.
// - power byte reads show commanded switch state only.
// - any write in A000h-AFFFh updates power byte and slot switches.
// - power byte resets to 11011111b, all drives on.
// - power bits 4:0 switch slot n; 1 on, 0 off.
// - power bit 7 shows chassis strap, 1 internal, 0 external.
// - power bit 5 shows scsi id input; bit 6 reserved.
// - any write in B000h-BFFFh loads fault byte; resets to 00h.
// - fault bits 4:0 light slot lamps; bits 7:5 reserved.
// - reads in C000h-CFFFh return presence byte, bits 4:0 occupancy.
// - presence bit 6 follows primary jumper, 1 primary.
// - presence bit 5 reads 0 when force update jumper is active.
// - D000h-DFFFh reaches scsi controller registers via low three lines.
// - E000h-FFFFh maps 8 KB ram usable as code and data.
`timescale 1ns/1ns
module bmmd_decode
    import bmmd_pkg::*;
(
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    // microcontroller bus
    input  wire logic                         addr_latch_en,
    input  wire logic [7:0]                   low_addr_data_port_in,
    output logic      [7:0]                   low_addr_data_port_out,
    output logic                              low_addr_data_port_oe_n,
    input  wire logic [7:0]                   high_addr_port,
    input  wire logic                         rd_n,
    input  wire logic                         wr_n,
    // straps and jumpers
    input  wire logic                         boot_write_enable,
    input  wire logic                         chassis_internal,
    input  wire logic                         scsi_id_select,
    input  wire logic                         primary_jumper,
    input  wire logic                         force_update_n,
    input  wire logic [SLOT_COUNT-1:0]        slot_occupied,
    // flash program memory
    output logic                              flash_ce_n,
    output logic                              flash_oe_n,
    output logic                              flash_we_n,
    output logic      [15:0]                  mem_addr,
    output logic      [7:0]                   mem_wdata,
    input  wire logic [7:0]                   flash_rdata,
    // scsi controller
    output logic                              scsi_dma_ack_n,
    output logic                              scsi_cs_n,
    output logic                              scsi_rd_n,
    output logic                              scsi_wr_n,
    output logic      [SCSI_IO_ADDR_BITS-1:0] scsi_reg_addr,
    input  wire logic [7:0]                   scsi_rdata,
    // drive slot controls
    output logic      [SLOT_COUNT-1:0]        slot_power_switch,
    output logic      [SLOT_COUNT-1:0]        slot_fault_lamp
);

    // ---------------------------------------------------------------
    // decode function
    // ---------------------------------------------------------------

    // region from the top four address bits
    function automatic bmmd_region_type region_of(input logic [15:0] a);
        bmmd_region_type r;
        r = BMMD_RAM;
        if (a[15:12] <= REG_TOP_PROG_LAST)
            r = BMMD_PROG;
        else if (a[15:12] == REG_SCSI_BUF)
            r = BMMD_SCSI_BUF;
        else if (a[15:12] == REG_POWER)
            r = BMMD_POWER;
        else if (a[15:12] == REG_FAULT)
            r = BMMD_FAULT;
        else if (a[15:12] == REG_PRESENCE)
            r = BMMD_PRESENCE;
        else if (a[15:12] == REG_SCSI_IO)
            r = BMMD_SCSI_IO;
        return r;
    endfunction : region_of

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam int SYNC_W = 13 + SLOT_COUNT;

    logic [SYNC_W-1:0]     sync_in;
    logic [SYNC_W-1:0]     sync_q;
    logic                  ale_s;
    logic                  rd_on_s;
    logic                  wr_on_s;
    logic                  boot_we_s;
    logic                  chassis_s;
    logic                  scsi_id_s;
    logic                  primary_s;
    logic                  force_upd_n_s;
    logic [SLOT_COUNT-1:0] occupied_s;
    logic [7:0]            high_s;

    // strobes enter inverted so a flushed synchroniser reads as an idle bus
    assign sync_in = {addr_latch_en, !rd_n, !wr_n, boot_write_enable, chassis_internal,
                      scsi_id_select, primary_jumper, force_update_n, slot_occupied,
                      high_addr_port[7:3]};

    bmmd_sync #(.WIDTH(SYNC_W)) u_sync
    (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (sync_in),
        .sync_out (sync_q)
    );

    // split the synchronised bundle back into named levels
    assign {ale_s, rd_on_s, wr_on_s, boot_we_s, chassis_s, scsi_id_s, primary_s,
            force_upd_n_s, occupied_s, high_s[7:3]} = sync_q;

    // ---------------------------------------------------------------
    // address and data capture
    // ---------------------------------------------------------------
    logic       ale_d_reg;
    logic [7:0] low_addr_reg;
    logic [7:0] data_s1_reg;
    logic [7:0] data_s2_reg;
    logic [2:0] high_low_s1_reg;
    logic [2:0] high_low_s2_reg;
    logic [15:0] addr_reg;

    // bus pins pass two flops before use
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            data_s1_reg     <= 8'h00;
            data_s2_reg     <= 8'h00;
            high_low_s1_reg <= 3'h0;
            high_low_s2_reg <= 3'h0;
        end
        else
        begin
            data_s1_reg     <= low_addr_data_port_in;
            data_s2_reg     <= data_s1_reg;
            high_low_s1_reg <= high_addr_port[2:0];
            high_low_s2_reg <= high_low_s1_reg;
        end
    end

    // low high-address bits come from their own flop pair
    assign high_s[2:0] = high_low_s2_reg;

    // low address latched on the falling edge of the latch enable
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ale_d_reg    <= 1'b0;
            low_addr_reg <= 8'h00;
        end
        else
        begin
            ale_d_reg <= ale_s;
            if (ale_d_reg && !ale_s)
                low_addr_reg <= data_s2_reg;
        end
    end

    // full byte address of the cycle in progress
    assign addr_reg = {high_s, low_addr_reg};

    // ---------------------------------------------------------------
    // strobe decode
    // ---------------------------------------------------------------
    bmmd_region_type region;
    logic            rd_act;
    logic            wr_act;
    logic            wr_n_d_reg;
    logic            wr_rise;
    logic            boot_hit;

    assign region   = region_of(addr_reg);
    assign rd_act   = rd_on_s;
    assign wr_act   = wr_on_s;
    // trailing edge of the write strobe, data has settled by then
    assign wr_rise  = !wr_n_d_reg && !wr_on_s;
    assign boot_hit = (addr_reg[15:13] == BOOT_TOP3);

    // write strobe history for commit on trailing edge
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            wr_n_d_reg <= 1'b1;
        else
            wr_n_d_reg <= !wr_on_s;
    end

    // ---------------------------------------------------------------
    // flash and scsi strobes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            flash_ce_n     <= 1'b1;
            flash_oe_n     <= 1'b1;
            flash_we_n     <= 1'b1;
            scsi_dma_ack_n <= 1'b1;
            scsi_cs_n      <= 1'b1;
            scsi_rd_n      <= 1'b1;
            scsi_wr_n      <= 1'b1;
            scsi_reg_addr  <= '0;
            mem_addr       <= 16'h0000;
            mem_wdata      <= 8'h00;
        end
        else
        begin
            mem_addr      <= addr_reg;
            mem_wdata     <= data_s2_reg;
            scsi_reg_addr <= addr_reg[SCSI_IO_ADDR_BITS-1:0];
            flash_ce_n    <= !(region == BMMD_PROG && (rd_act || wr_act));
            flash_oe_n    <= !(region == BMMD_PROG && rd_act);
            flash_we_n    <= !(region == BMMD_PROG && wr_act
                               && (!boot_hit || boot_we_s));
            scsi_dma_ack_n <= !(region == BMMD_SCSI_BUF
                                && (rd_act || wr_act));
            scsi_cs_n      <= !(region == BMMD_SCSI_IO
                                && (rd_act || wr_act));
            scsi_rd_n      <= !((region == BMMD_SCSI_BUF || region == BMMD_SCSI_IO)
                                && rd_act);
            scsi_wr_n      <= !((region == BMMD_SCSI_BUF || region == BMMD_SCSI_IO)
                                && wr_act);
        end
    end

    // ---------------------------------------------------------------
    // control bytes
    // ---------------------------------------------------------------
    logic [SLOT_COUNT-1:0] power_bits_reg;
    logic [SLOT_COUNT-1:0] fault_bits_reg;

    // power switches, any alias, commit when write ends
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            power_bits_reg <= DRIVE_POWER_RESET[SLOT_COUNT-1:0];
        else if (wr_rise && region == BMMD_POWER)
            power_bits_reg <= data_s2_reg[SLOT_COUNT-1:0];
    end

    // fault lamps, write only
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            fault_bits_reg <= FAULT_LAMP_RESET[SLOT_COUNT-1:0];
        else if (wr_rise && region == BMMD_FAULT)
            fault_bits_reg <= data_s2_reg[SLOT_COUNT-1:0];
    end

    // control bytes drive the slot pins directly
    assign slot_power_switch = power_bits_reg;
    assign slot_fault_lamp   = fault_bits_reg;

    // ---------------------------------------------------------------
    // ram
    // ---------------------------------------------------------------
    logic [7:0] ram_rdata;
    logic       ram_we;

    // ram write commits on the trailing edge like the control bytes
    assign ram_we = wr_rise && region == BMMD_RAM;

    bmmd_ram u_ram
    (
        .mclk  (mclk),
        .wr_en (ram_we),
        .addr  (addr_reg[RAM_ADDR_BITS-1:0]),
        .wdata (data_s2_reg),
        .rdata (ram_rdata)
    );

    // ---------------------------------------------------------------
    // read data return
    // ---------------------------------------------------------------
    logic [7:0] power_byte;
    logic [7:0] presence_byte;
    logic [7:0] rdata_next;

    // power byte holds commanded state, not supply health
    always_comb
    begin
        power_byte                  = DRIVE_POWER_RESET; // reserved bit 6 as in default
        power_byte[SLOT_COUNT-1:0]  = power_bits_reg;
        power_byte[PWR_CHASSIS_BIT] = chassis_s;
        power_byte[PWR_SCSI_ID_BIT] = scsi_id_s;
    end

    // presence byte from synchronised straps
    always_comb
    begin
        presence_byte                    = 8'h00;
        presence_byte[SLOT_COUNT-1:0]    = occupied_s;
        presence_byte[PRS_PRIMARY_BIT]   = primary_s;
        presence_byte[PRS_FORCE_UPD_BIT] = force_upd_n_s;
    end

    // read mux by region
    always_comb
    begin
        unique case (region)
            BMMD_PROG:     rdata_next = flash_rdata;
            BMMD_SCSI_BUF: rdata_next = scsi_rdata;
            BMMD_POWER:    rdata_next = power_byte;
            BMMD_FAULT:    rdata_next = 8'h00;
            BMMD_PRESENCE: rdata_next = presence_byte;
            BMMD_SCSI_IO:  rdata_next = scsi_rdata;
            BMMD_RAM:      rdata_next = ram_rdata;
        endcase
    end

    // drive port only while the read strobe is low; fault byte never driven
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            low_addr_data_port_out  <= 8'h00;
            low_addr_data_port_oe_n <= 1'b1;
        end
        else
        begin
            low_addr_data_port_out  <= rdata_next;
            low_addr_data_port_oe_n <= !(rd_act && region != BMMD_FAULT);
        end
    end

endmodule : bmmd_decode

/* File: bmmd_decode_props.sv */
// checker: port-level timing and decode relations of the backplane decode
`timescale 1ns/1ns
module bmmd_decode_props
    import bmmd_pkg::*;
(
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    // bus and straps
    input wire logic                  rd_n,
    input wire logic                  wr_n,
    input wire logic                  boot_write_enable,
    input wire logic                  low_addr_data_port_oe_n,
    // memory and scsi strobes
    input wire logic                  flash_ce_n,
    input wire logic                  flash_oe_n,
    input wire logic                  flash_we_n,
    input wire logic [15:0]           mem_addr,
    input wire logic                  scsi_dma_ack_n,
    input wire logic                  scsi_cs_n,
    input wire logic                  scsi_rd_n,
    input wire logic                  scsi_wr_n,
    // slot controls
    input wire logic [SLOT_COUNT-1:0] slot_power_switch,
    input wire logic [SLOT_COUNT-1:0] slot_fault_lamp
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    property p_boot_lock;
        !flash_we_n && mem_addr[15:13] == BOOT_TOP3 |-> boot_write_enable;
    endproperty
    a_boot_lock: assert property (p_boot_lock) else $error("boot block write not blocked");
    property p_power_rst;
        $fell(sys_rst) |-> slot_power_switch == 5'h1F;
    endproperty
    a_power_rst: assert property (p_power_rst) else $error("power switches not all on");
    property p_fault_rst;
        $fell(sys_rst) |-> slot_fault_lamp == 5'h00;
    endproperty
    a_fault_rst: assert property (p_fault_rst) else $error("fault lamps not off");
    property p_dma_strobe;
        !scsi_dma_ack_n |-> scsi_rd_n != scsi_wr_n;
    endproperty
    a_dma_strobe: assert property (p_dma_strobe) else $error("dma ack without one strobe");
    property p_region_excl;
        !scsi_cs_n |-> scsi_dma_ack_n && flash_ce_n;
    endproperty
    a_region_excl: assert property (p_region_excl) else $error("two regions selected");
    property p_io_strobe;
        !scsi_cs_n |-> !scsi_rd_n || !scsi_wr_n;
    endproperty
    a_io_strobe: assert property (p_io_strobe) else $error("scsi select without strobe");
    property p_drive_after_rd;
        !low_addr_data_port_oe_n |-> !$past(rd_n, 3) && wr_n;
    endproperty
    a_drive_after_rd: assert property (p_drive_after_rd) else $error("port driven unasked");
    property p_power_commit;
        !$stable(slot_power_switch) |-> wr_n && !$past(wr_n, 4);
    endproperty
    a_power_commit: assert property (p_power_commit) else $error("power byte changed off write");
    property p_lamp_commit;
        !$stable(slot_fault_lamp) |-> wr_n && !$past(wr_n, 4);
    endproperty
    a_lamp_commit: assert property (p_lamp_commit) else $error("fault byte changed off write");
    property p_flash_we;
        !flash_we_n |-> !flash_ce_n && flash_oe_n;
    endproperty
    a_flash_we: assert property (p_flash_we) else $error("flash write strobe malformed");
endmodule : bmmd_decode_props

/* File: bmmd_mcu_model.sv */
// partner: microcontroller external bus master issuing byte cycles
`timescale 1ns/1ns
module bmmd_mcu_model
    import bmmd_pkg::*;
(
    // clock
    input wire logic        mclk,
    // bus driven by the controller
    output logic            addr_latch_en,
    output logic [7:0]      low_addr_data_port_in,
    output logic [7:0]      high_addr_port,
    output logic            rd_n,
    output logic            wr_n,
    // read answer
    input wire logic [7:0]  low_addr_data_port_out,
    input wire logic        low_addr_data_port_oe_n
);
    // idle bus at time zero
    initial
    begin
        addr_latch_en = 1'b0;
        low_addr_data_port_in = 8'hFF;
        high_addr_port = 8'h00;
        rd_n = 1'b1;
        wr_n = 1'b1;
    end

    // latch pulse with multiplexed low byte, high byte held for the cycle
    task automatic addr_phase(input logic [15:0] a);
        @(posedge mclk);
        addr_latch_en <= 1'b1;
        low_addr_data_port_in <= a[7:0];
        high_addr_port <= a[15:8];
        repeat (3) @(posedge mclk);
        addr_latch_en <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : addr_phase

    // write cycle, data held past the strobe trailing edge
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        addr_phase(a);
        low_addr_data_port_in <= d;
        wr_n <= 1'b0;
        repeat (5) @(posedge mclk);
        wr_n <= 1'b1;
        repeat (5) @(posedge mclk);
        low_addr_data_port_in <= ~d;
    endtask : bus_write

    // read cycle, port released (inverted) while the device answers
    task automatic bus_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
        addr_phase(a);
        low_addr_data_port_in <= ~a[7:0];
        rd_n <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        d = low_addr_data_port_out;
        oe = low_addr_data_port_oe_n;
        @(posedge mclk);
        rd_n <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask : bus_read
endmodule : bmmd_mcu_model

/* File: test_backplane_memory_map_decode.sv */
// testbench: memory map decode, control bytes and strobes of the backplane
`timescale 1ns/1ns
module test_backplane_memory_map_decode
    import bmmd_pkg::*;
;
    logic       mclk = 1'b0, sys_rst = 1'b1, ale, rd_n, wr_n, oe_n, rd_oe;
    logic [7:0] p_in, p_out, hi, flash_rdata, scsi_rdata, rdat;
    logic       boot_write_enable, chassis_internal, scsi_id_select, primary_jumper;
    logic       force_update_n, ce_n, foe_n, we_n, ack_n, cs_n, srd_n, swr_n;
    logic [4:0] slot_occupied, pwr, lamp, seen;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, shadow;
    logic [2:0] reg_addr, last_reg;
    logic [23:0] last_wr;
    int         errors = 0, cmp_count = 0;

    always #25 mclk = ~mclk;

    bmmd_mcu_model u_mcu (.mclk(mclk), .addr_latch_en(ale), .low_addr_data_port_in(p_in),
        .high_addr_port(hi), .rd_n(rd_n), .wr_n(wr_n), .low_addr_data_port_out(p_out),
        .low_addr_data_port_oe_n(oe_n));
    bmmd_decode uut (.mclk(mclk), .sys_rst(sys_rst), .addr_latch_en(ale),
        .low_addr_data_port_in(p_in), .low_addr_data_port_out(p_out),
        .low_addr_data_port_oe_n(oe_n), .high_addr_port(hi), .rd_n(rd_n), .wr_n(wr_n),
        .boot_write_enable(boot_write_enable), .chassis_internal(chassis_internal),
        .scsi_id_select(scsi_id_select), .primary_jumper(primary_jumper),
        .force_update_n(force_update_n), .slot_occupied(slot_occupied),
        .flash_ce_n(ce_n), .flash_oe_n(foe_n), .flash_we_n(we_n), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .flash_rdata(flash_rdata), .scsi_dma_ack_n(ack_n),
        .scsi_cs_n(cs_n), .scsi_rd_n(srd_n), .scsi_wr_n(swr_n), .scsi_reg_addr(reg_addr),
        .scsi_rdata(scsi_rdata), .slot_power_switch(pwr), .slot_fault_lamp(lamp));

    // sticky strobe monitor: flash we, dma ack, scsi rd, scsi wr, scsi cs
    always @(negedge mclk)
    begin
        seen = seen | {!we_n, !ack_n, !srd_n, !swr_n, !cs_n};
        if (cs_n === 1'b0)
            last_reg = reg_addr;
        if (we_n === 1'b0)
            last_wr = {mem_addr, mem_wdata};
    end

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        seen = 5'h00;
        u_mcu.bus_write(a, d);
    endtask : wr

    task automatic rd(input logic [15:0] a);
        seen = 5'h00;
        u_mcu.bus_read(a, rdat, rd_oe);
    endtask : rd

    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // watchdog far beyond the roughly 390 cycles of the sequence
    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        summarize();
    end

    initial
    begin
        {boot_write_enable, scsi_id_select, primary_jumper} = 3'b001;
        {chassis_internal, force_update_n} = 2'b11;
        slot_occupied = 5'h13;
        flash_rdata = 8'h5A;
        scsi_rdata = 8'hC3;
        seen = 5'h00;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check("power_sw", {3'h0, pwr}, 8'h1F);
        check("fault_lamp", {3'h0, lamp}, 8'h00);
        rd(16'hA000);
        check("power_rd", rdat, DRIVE_POWER_RESET);
        $display("test reset defaults done");
        chassis_internal <= 1'b0;
        scsi_id_select <= 1'b1;
        wr(16'hAFFF, 8'hCA);
        check("power_sw", {3'h0, pwr}, 8'h0A);
        rd(16'hA555);
        check("power_rd", rdat, 8'h6A);
        $display("test power byte done");
        shadow = 8'hF5;
        wr(16'hB7FF, shadow);
        check("fault_lamp", {3'h0, lamp}, 8'h15);
        shadow = shadow & 8'hFE;
        wr(16'hBFFF, shadow);
        check("fault_lamp", {3'h0, lamp}, 8'h14);
        rd(16'hB000);
        check("fault_rd_oe_n", {7'h0, rd_oe}, 8'h01);
        check("power_sw", {3'h0, pwr}, 8'h0A);
        $display("test fault byte done");
        {force_update_n, primary_jumper} <= 2'b00;
        slot_occupied <= 5'h0D; // of the newly seated slots 2 and 3, only slot 2 is unpowered here
        rd(16'hCABC);
        check("presence", rdat, 8'h0D);
        {force_update_n, primary_jumper} <= 2'b11;
        wr(16'hC000, 8'hFF);
        rd(16'hCFFF);
        check("presence", rdat, 8'h6D);
        $display("test presence byte done");
        wr(16'h2000, 8'h11);
        check("flash_we", {7'h0, seen[4]}, 8'h01);
        check("flash_addr", last_wr[23:16], 8'h20);
        check("flash_wdata", last_wr[7:0], 8'h11);
        wr(16'h0100, 8'h22);
        check("boot_we", {7'h0, seen[4]}, 8'h00);
        boot_write_enable <= 1'b1;
        wr(16'h1FFF, 8'h33);
        check("boot_we", {7'h0, seen[4]}, 8'h01);
        rd(16'h8FFF);
        check("flash_rd", rdat, 8'h5A);
        check("flash_rd_oe_n", {7'h0, rd_oe}, 8'h00);
        $display("test program memory done");
        rd(16'h9123);
        check("buf_rd", rdat, 8'hC3);
        check("buf_rd_strobes", {3'h0, seen}, 8'h0C);
        wr(16'h9FFE, 8'h77);
        check("buf_wr_strobes", {3'h0, seen}, 8'h0A);
        scsi_rdata <= 8'h3E;
        rd(16'hD03A);
        check("io_rd", rdat, 8'h3E);
        check("io_rd_strobes", {3'h0, seen}, 8'h05);
        check("io_reg", {5'h0, last_reg}, 8'h02);
        wr(16'hD005, 8'h44);
        check("io_wr_strobes", {3'h0, seen}, 8'h03);
        check("io_reg", {5'h0, last_reg}, 8'h05);
        $display("test scsi windows done");
        wr(16'hE001, 8'h3C);
        wr(16'hFFFF, 8'hA5);
        rd(16'hE001);
        check("ram_lo", rdat, 8'h3C);
        rd(16'hFFFF);
        check("ram_hi", rdat, 8'hA5);
        check("ram_no_flash", {7'h0, seen[4]}, 8'h00);
        $display("test ram done");
        summarize();
    end
endmodule : test_backplane_memory_map_decode

bind bmmd_decode bmmd_decode_props u_props (.mclk(mclk), .sys_rst(sys_rst), .rd_n(rd_n),
    .wr_n(wr_n), .boot_write_enable(boot_write_enable),
    .low_addr_data_port_oe_n(low_addr_data_port_oe_n), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .mem_addr(mem_addr),
    .scsi_dma_ack_n(scsi_dma_ack_n), .scsi_cs_n(scsi_cs_n), .scsi_rd_n(scsi_rd_n),
    .scsi_wr_n(scsi_wr_n), .slot_power_switch(slot_power_switch),
    .slot_fault_lamp(slot_fault_lamp));
